//--- verilog/recorder_pkg.sv
// Purpose: shared constants and types of the fault and event recorder
// Assumes: one 50 MHz clock, synchronous active-low reset
// Notes:   times are kept in their own unit and converted to cycles here
package recorder_pkg;
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned BACKLIGHT_S   = 20;
	localparam int unsigned HOLD_S        = 5;
	localparam int unsigned STAMP_MS      = 1;
	localparam int unsigned BACKLIGHT_CYC = BACKLIGHT_S * CLK_HZ;
	localparam int unsigned HOLD_CYC      = HOLD_S * CLK_HZ;
	localparam int unsigned MS_CYC        = STAMP_MS * CLK_HZ / 1000;

	localparam int SMP_W    = 16;
	localparam int SPC      = 32;
	localparam int PRE_CYC  = 45;
	localparam int POST_CYC = 5;
	localparam int REC_LEN  = SPC * (PRE_CYC + POST_CYC);
	localparam int POST_LEN = SPC * POST_CYC;
	localparam int NUM_REC  = 200;
	localparam int NUM_EVT  = 5000;
	localparam int WAVE_AW  = 19;
	localparam int OFS_W    = 11;
	localparam int REC_W    = 8;
	localparam int EVT_AW   = 13;
	localparam int TS_W     = 32;
	localparam int STAT_W   = 13;
	localparam int NUM_EVK  = 10;
	localparam int EVT_W    = TS_W + 4 + SMP_W + SMP_W;

	localparam logic [3:0] EV_PROT_TRIP = 4'h0;
	localparam logic [3:0] EV_TCS       = 4'h1;
	localparam logic [3:0] EV_PICKUP    = 4'h2;
	localparam logic [3:0] EV_RESET     = 4'h3;
	localparam logic [3:0] EV_CB_TRIP   = 4'h4;
	localparam logic [3:0] EV_CB_CLOSE  = 4'h5;
	localparam logic [3:0] EV_STATUS    = 4'h6;
	localparam logic [3:0] EV_SET_GUI   = 4'h7;
	localparam logic [3:0] EV_SET_KEY   = 4'h8;
	localparam logic [3:0] EV_ERROR     = 4'h9;

	localparam logic [1:0] FT_NONE = 2'h0;
	localparam logic [1:0] FT_OVER = 2'h1;
	localparam logic [1:0] FT_INST = 2'h2;

	localparam logic [31:0] CNT_RST = 32'h0000_0000;

	typedef enum logic [3:0] {
		RD_IDLE = 4'b0001,
		RD_TAB  = 4'b0010,
		RD_MEM  = 4'b0100,
		RD_OUT  = 4'b1000
	} rd_state_type;

	typedef enum logic [1:0] {
		PANEL_RUN = 2'b01,
		PANEL_SET = 2'b10
	} panel_state_type;
endpackage : recorder_pkg

//--- verilog/record_mem.sv
// Purpose: simple dual-port store, one write and one registered read
// Assumes: read and write on the same clock
// Notes:   read data lag the address by one edge
`timescale 1ns/1ps
`default_nettype none
module record_mem #(
	parameter int W  = 16,
	parameter int D  = 1024,
	parameter int AW = 10
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] wa,
	input  wire logic [W-1:0]  wd,
	input  wire logic [AW-1:0] ra,
	output logic      [W-1:0]  rd
);
	logic [W-1:0] mem [D];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[wa] <= wd;
		end
	end

	always_ff @(posedge clk) begin
		rd <= mem[ra];
	end
endmodule : record_mem
`default_nettype wire

//--- verilog/key_panel.sv
// Purpose: front keys, backlight timeout and settings-mode entry
// Assumes: keys are debounced, high while pressed
// Notes:   long counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
module key_panel
	import recorder_pkg::*;
#(
	parameter int unsigned BL_CYCLES   = BACKLIGHT_CYC,
	parameter int unsigned HOLD_CYCLES = HOLD_CYC
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic menu_key,
	input  wire logic inc_key,
	input  wire logic dec_key,
	input  wire logic records_key,
	input  wire logic hand_reset_key,
	input  wire logic trip_active,
	input  wire logic settings_done,
	output logic      backlight_on,
	output logic      settings_mode,
	output logic      select_pulse,
	output logic      inc_pulse,
	output logic      dec_pulse,
	output logic      records_view,
	output logic      relay_reset
);
	logic [4:0]      keys_q;
	logic [4:0]      press;
	logic            trip_q;
	logic [31:0]     bl_q;
	logic [31:0]     bl_d;
	logic [31:0]     hold_q;
	panel_state_type st_q;

	assign press = {hand_reset_key, records_key, dec_key, inc_key, menu_key} & ~keys_q;
	assign settings_mode = (st_q == PANEL_SET);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			keys_q <= 5'h00;
			trip_q <= 1'b0;
		end else begin
			keys_q <= {hand_reset_key, records_key, dec_key, inc_key, menu_key};
			trip_q <= trip_active;
		end
	end

	// Hand reset (bit 4) deliberately left out of the reload
	always_comb begin
		if ((|press[3:0]) || (trip_active && !trip_q)) begin
			bl_d = BL_CYCLES;
		end else if (bl_q != CNT_RST) begin
			bl_d = bl_q - 32'h0000_0001;
		end else begin
			bl_d = bl_q;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			bl_q         <= CNT_RST;
			backlight_on <= 1'b0;
		end else begin
			bl_q         <= bl_d;
			backlight_on <= (bl_d != CNT_RST);
		end
	end

	// Hold timer only runs while not tripped, so a reset press starts its hold count only once the trip clears
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_q   <= PANEL_RUN;
			hold_q <= CNT_RST;
		end else begin
			unique case (st_q)
				PANEL_RUN: begin
					if (menu_key && !trip_active) begin
						if (hold_q == HOLD_CYCLES - 1) begin
							st_q   <= PANEL_SET;
							hold_q <= CNT_RST;
						end else begin
							hold_q <= hold_q + 32'h0000_0001;
						end
					end else begin
						hold_q <= CNT_RST;
					end
				end
				PANEL_SET: begin
					if (settings_done) begin
						st_q <= PANEL_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			select_pulse <= 1'b0;
			inc_pulse    <= 1'b0;
			dec_pulse    <= 1'b0;
			relay_reset  <= 1'b0;
		end else begin
			select_pulse <= settings_mode && press[0];
			inc_pulse    <= settings_mode && press[1];
			dec_pulse    <= settings_mode && press[2];
			relay_reset  <= press[4] || (press[0] && trip_active && !settings_mode);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			records_view <= 1'b0;
		end else if (settings_mode) begin
			records_view <= 1'b0;
		end else if (press[3]) begin
			records_view <= !records_view;
		end
	end
endmodule : key_panel
`default_nettype wire

//--- verilog/fault_event_disturbance_recorder.sv
// Purpose: trip detection, disturbance capture, event log and record read-out
// Assumes: converter paces samples at 32 per cycle; inputs are synchronous
// Notes:   stores stand for the non-volatile memory behind them
`timescale 1ns/1ps
`default_nettype none
module fault_event_disturbance_recorder
	import recorder_pkg::*;
#(
	parameter int unsigned MS_CYCLES   = MS_CYC,
	parameter int unsigned BL_CYCLES   = BACKLIGHT_CYC,
	parameter int unsigned HOLD_CYCLES = HOLD_CYC,
	parameter int          NREC        = NUM_REC,
	parameter int          NEVT        = NUM_EVT
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              menu_key,
	input  wire logic              inc_key,
	input  wire logic              dec_key,
	input  wire logic              records_key,
	input  wire logic              hand_reset_key,
	input  wire logic              settings_done,
	input  wire logic              gui_setting_changed,
	input  wire logic              smp_valid,
	input  wire logic [SMP_W-1:0]  smp_data,
	input  wire logic [SMP_W-1:0]  pickup_level,
	input  wire logic [SMP_W-1:0]  trip_level,
	input  wire logic [SMP_W-1:0]  inst_level,
	input  wire logic [STAT_W-1:0] status_in,
	input  wire logic              cb_open,
	input  wire logic              cb_closed,
	input  wire logic              tcs_fail,
	input  wire logic              relay_error,
	input  wire logic              front_rd_req,
	input  wire logic              front_rd_event,
	input  wire logic [REC_W-1:0]  front_rd_rec,
	input  wire logic [EVT_AW-1:0] front_rd_idx,
	input  wire logic              rear_rd_req,
	input  wire logic              rear_rd_event,
	input  wire logic [REC_W-1:0]  rear_rd_rec,
	input  wire logic [EVT_AW-1:0] rear_rd_idx,
	output logic                   front_rd_busy,
	output logic                   rear_rd_busy,
	output logic                   front_rd_valid,
	output logic                   rear_rd_valid,
	output logic      [EVT_W-1:0]  rd_data,
	output logic                   backlight_on,
	output logic                   settings_mode,
	output logic                   select_pulse,
	output logic                   inc_pulse,
	output logic                   dec_pulse,
	output logic                   records_view,
	output logic                   trip_cmd,
	output logic      [1:0]        fault_type,
	output logic                   pickup,
	output logic      [TS_W-1:0]   timestamp_ms,
	output logic      [REC_W-1:0]  wave_count,
	output logic      [REC_W-1:0]  newest_rec,
	output logic      [EVT_AW-1:0] event_count
);
	function automatic logic [OFS_W-1:0] ofs_add(input logic [OFS_W-1:0] a,
			input logic [OFS_W-1:0] b);
		logic [OFS_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= (OFS_W+1)'(REC_LEN)) begin
			s = s - (OFS_W+1)'(REC_LEN);
		end
		return s[OFS_W-1:0];
	endfunction : ofs_add

	function automatic logic [WAVE_AW-1:0] rec_addr(input logic [REC_W-1:0] r,
			input logic [OFS_W-1:0] o);
		return WAVE_AW'(r) * WAVE_AW'(REC_LEN) + WAVE_AW'(o);
	endfunction : rec_addr

	function automatic logic [3:0] first_set(input logic [NUM_EVK-1:0] v);
		logic [3:0] k;
		k = 4'h0;
		for (int i = NUM_EVK - 1; i >= 0; i--) begin
			if (v[i]) begin
				k = 4'(i);
			end
		end
		return k;
	endfunction : first_set

	logic relay_reset;

	key_panel #(
		.BL_CYCLES   (BL_CYCLES),
		.HOLD_CYCLES (HOLD_CYCLES)
	) u_panel (
		.core_clk       (core_clk),
		.rst_n          (rst_n),
		.menu_key       (menu_key),
		.inc_key        (inc_key),
		.dec_key        (dec_key),
		.records_key    (records_key),
		.hand_reset_key (hand_reset_key),
		.trip_active    (trip_cmd),
		.settings_done  (settings_done),
		.backlight_on   (backlight_on),
		.settings_mode  (settings_mode),
		.select_pulse   (select_pulse),
		.inc_pulse      (inc_pulse),
		.dec_pulse      (dec_pulse),
		.records_view   (records_view),
		.relay_reset    (relay_reset)
	);

	// Millisecond time base
	logic [31:0] ms_div_q;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ms_div_q     <= CNT_RST;
			timestamp_ms <= CNT_RST;
		end else if (ms_div_q == MS_CYCLES - 1) begin
			ms_div_q     <= CNT_RST;
			timestamp_ms <= timestamp_ms + 32'h0000_0001;
		end else begin
			ms_div_q <= ms_div_q + 32'h0000_0001;
		end
	end

	// Protection: magnitude of a signed 16-bit sample
	logic [SMP_W-1:0] mag;
	logic [SMP_W-1:0] peak_q;
	logic [SMP_W-1:0] clr_time_q;
	logic [TS_W-1:0]  trip_ts_q;
	logic [5:0]       quiet_q;
	logic             meas_q;
	logic             trip_log;
	logic             trip_hit;
	logic             trip_rise;

	assign mag = smp_data[SMP_W-1] ? SMP_W'(-smp_data) : smp_data;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pickup <= 1'b0;
		end else if (smp_valid) begin
			pickup <= (mag > pickup_level);
		end
	end

	// A fault still present beats a reset press in the same cycle
	assign trip_hit  = smp_valid && (mag > trip_level);
	assign trip_rise = trip_hit && !trip_cmd;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			trip_cmd   <= 1'b0;
			fault_type <= FT_NONE;
			trip_ts_q  <= CNT_RST;
		end else if (trip_rise) begin
			trip_cmd   <= 1'b1;
			fault_type <= (mag > inst_level) ? FT_INST : FT_OVER;
			trip_ts_q  <= timestamp_ms;
		end else if (relay_reset && !trip_hit) begin
			trip_cmd   <= 1'b0;
			fault_type <= FT_NONE;
		end
	end

	// Clearing is one full cycle of samples below pickup after the trip
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			meas_q     <= 1'b0;
			quiet_q    <= 6'h00;
			peak_q     <= 16'h0000;
			clr_time_q <= 16'h0000;
			trip_log   <= 1'b0;
		end else begin
			trip_log <= 1'b0;
			if (trip_rise) begin
				meas_q  <= 1'b1;
				quiet_q <= 6'h00;
				peak_q  <= mag;
			end else if (smp_valid && meas_q) begin
				if (mag > peak_q) begin
					peak_q <= mag;
				end
				if (mag > pickup_level) begin
					quiet_q <= 6'h00;
				end else if (quiet_q == 6'(SPC - 1)) begin
					meas_q     <= 1'b0;
					trip_log   <= 1'b1;
					clr_time_q <= SMP_W'(timestamp_ms - trip_ts_q);
				end else begin
					quiet_q <= quiet_q + 6'h01;
				end
			end
		end
	end

	// Disturbance capture: each slot is itself the circular pre-fault ring
	logic [OFS_W-1:0] wp_q;
	logic [7:0]       post_q;
	logic             cap_q;
	logic             cap_done;
	logic [OFS_W-1:0] tab_rd;

	assign cap_done = smp_valid && cap_q && (post_q == 8'h01);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wp_q       <= 11'h000;
			post_q     <= 8'h00;
			cap_q      <= 1'b0;
			newest_rec <= 8'h00;
			wave_count <= 8'h00;
		end else begin
			if (smp_valid) begin
				wp_q <= ofs_add(wp_q, 11'h001);
			end
			// Trigger sample is the first of the post part
			if (trip_rise && !cap_q) begin
				cap_q  <= 1'b1;
				post_q <= 8'(POST_LEN - 1);
			end else if (cap_done) begin
				cap_q      <= 1'b0;
				newest_rec <= 8'(slot_next(newest_rec, wave_count));
				if (wave_count != 8'(NREC)) begin
					wave_count <= wave_count + 8'h01;
				end
			end else if (smp_valid && cap_q) begin
				post_q <= post_q - 8'h01;
			end
		end
	end

	// Slot being filled: the one after the newest, wrapping over the oldest
	function automatic logic [REC_W-1:0] slot_next(input logic [REC_W-1:0] n,
			input logic [REC_W-1:0] c);
		if (c == 8'h00) begin
			return 8'h00;
		end
		return (n == 8'(NREC - 1)) ? 8'h00 : n + 8'h01;
	endfunction : slot_next

	logic [REC_W-1:0] fill_slot;

	assign fill_slot = slot_next(newest_rec, wave_count);

	// Events: pending flags, a new event beats the clear of its own flag
	logic [NUM_EVK-1:0] pend_q;
	logic [NUM_EVK-1:0] new_ev;
	logic [NUM_EVK-1:0] grant;
	logic [STAT_W-1:0]  stat_q;
	logic [4:0]         prev_q;
	logic [3:0]         ev_code;
	logic [EVT_W-1:0]   ev_word;
	logic [EVT_AW-1:0]  evt_wp_q;

	assign new_ev = {relay_error && !prev_q[4],
			settings_done && settings_mode,
			gui_setting_changed,
			status_in != stat_q,
			cb_closed && !prev_q[3],
			cb_open && !prev_q[2],
			relay_reset,
			smp_valid && (mag > pickup_level) && !pickup,
			tcs_fail != prev_q[1],
			trip_log};
	assign ev_code = first_set(pend_q);
	assign grant   = NUM_EVK'(|pend_q) << ev_code;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			// Follow the pins in reset, so an idle-high input logs no edge
			pend_q <= 10'h000;
			stat_q <= status_in;
			prev_q <= {relay_error, cb_closed, cb_open, tcs_fail, 1'b0};
		end else begin
			pend_q <= (pend_q & ~grant) | new_ev;
			stat_q <= status_in;
			prev_q <= {relay_error, cb_closed, cb_open, tcs_fail, 1'b0};
		end
	end

	always_comb begin
		ev_word = {timestamp_ms, ev_code, mag, 16'h0000};
		if (ev_code == EV_PROT_TRIP) begin
			ev_word = {trip_ts_q, ev_code, peak_q, clr_time_q};
		end else if (ev_code == EV_STATUS) begin
			ev_word = {timestamp_ms, ev_code, 3'h0, status_in, 16'h0000};
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			evt_wp_q    <= 13'h0000;
			event_count <= 13'h0000;
		end else if (|pend_q) begin
			evt_wp_q <= (evt_wp_q == 13'(NEVT - 1)) ? 13'h0000 : evt_wp_q + 13'h0001;
			if (event_count != 13'(NEVT)) begin
				event_count <= event_count + 13'h0001;
			end
		end
	end

	// Read-out for front and rear ports; front wins a tie
	rd_state_type     rd_st_q;
	logic             take_f;
	logic             take_r;
	logic             own_f_q;
	logic             ev_sel_q;
	logic             bad_q;
	logic [REC_W-1:0] rec_q;
	logic [EVT_AW-1:0] idx_q;
	logic [EVT_W-1:0]  evt_rd;
	logic [SMP_W-1:0]  wave_rd;
	logic              req_ev;
	logic [REC_W-1:0]  req_rec;
	logic [EVT_AW-1:0] req_idx;

	assign take_f        = front_rd_req && (rd_st_q == RD_IDLE);
	assign take_r        = rear_rd_req && !front_rd_req && (rd_st_q == RD_IDLE);
	assign front_rd_busy = (rd_st_q != RD_IDLE);
	assign rear_rd_busy  = (rd_st_q != RD_IDLE) || front_rd_req;
	assign req_ev        = front_rd_req ? front_rd_event : rear_rd_event;
	assign req_rec       = front_rd_req ? front_rd_rec : rear_rd_rec;
	assign req_idx       = front_rd_req ? front_rd_idx : rear_rd_idx;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_st_q  <= RD_IDLE;
			own_f_q  <= 1'b0;
			ev_sel_q <= 1'b0;
			bad_q    <= 1'b0;
			rec_q    <= 8'h00;
			idx_q    <= 13'h0000;
		end else begin
			unique case (rd_st_q)
				RD_IDLE: begin
					if (take_f || take_r) begin
						own_f_q  <= take_f;
						ev_sel_q <= req_ev;
						rec_q    <= req_rec;
						idx_q    <= req_idx;
						bad_q    <= req_ev ? (req_idx >= 13'(NEVT)) :
								((req_rec >= 8'(NREC)) || (req_idx >= 13'(REC_LEN)));
						rd_st_q  <= req_ev ? RD_MEM : RD_TAB;
					end
				end
				RD_TAB: rd_st_q <= RD_MEM;
				RD_MEM: rd_st_q <= RD_OUT;
				RD_OUT: rd_st_q <= RD_IDLE;
			endcase
		end
	end

	// Out-of-range requests answer zero rather than stale memory
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_data        <= {EVT_W{1'b0}};
			front_rd_valid <= 1'b0;
			rear_rd_valid  <= 1'b0;
		end else begin
			front_rd_valid <= (rd_st_q == RD_OUT) && own_f_q;
			rear_rd_valid  <= (rd_st_q == RD_OUT) && !own_f_q;
			if (rd_st_q == RD_OUT) begin
				if (bad_q) begin
					rd_data <= {EVT_W{1'b0}};
				end else if (ev_sel_q) begin
					rd_data <= evt_rd;
				end else begin
					rd_data <= EVT_W'(wave_rd);
				end
			end
		end
	end

	record_mem #(
		.W  (SMP_W),
		.D  (NREC * REC_LEN),
		.AW (WAVE_AW)
	) u_wave (
		.clk (core_clk),
		.we  (smp_valid),
		.wa  (rec_addr(fill_slot, wp_q)),
		.wd  (smp_data),
		.ra  (rec_addr(rec_q, ofs_add(tab_rd, OFS_W'(idx_q)))),
		.rd  (wave_rd)
	);

	record_mem #(
		.W  (OFS_W),
		.D  (NREC),
		.AW (REC_W)
	) u_start (
		.clk (core_clk),
		.we  (cap_done),
		.wa  (fill_slot),
		.wd  (ofs_add(wp_q, 11'h001)),
		.ra  (rec_q),
		.rd  (tab_rd)
	);

	record_mem #(
		.W  (EVT_W),
		.D  (NEVT),
		.AW (EVT_AW)
	) u_events (
		.clk (core_clk),
		.we  (|pend_q),
		.wa  (evt_wp_q),
		.wd  (ev_word),
		.ra  (idx_q),
		.rd  (evt_rd)
	);
endmodule : fault_event_disturbance_recorder
`default_nettype wire

//--- tb/recorder_sva.sv
// Purpose: port assertions of the recorder
// Assumes: bound to the top module
// Notes:   margins of up to three cycles absorb key register stages
`timescale 1ns/1ps
`default_nettype none
module recorder_sva
	import recorder_pkg::*;
#(
	parameter int unsigned BL_CYCLES	= BACKLIGHT_CYC,
	parameter int unsigned HOLD_CYCLES	= HOLD_CYC
) (
	input wire logic		core_clk,
	input wire logic		rst_n,
	input wire logic		menu_key,
	input wire logic		inc_key,
	input wire logic		dec_key,
	input wire logic		records_key,
	input wire logic		hand_reset_key,
	input wire logic		smp_valid,
	input wire logic [SMP_W-1:0]	smp_data,
	input wire logic [SMP_W-1:0]	trip_level,
	input wire logic		front_rd_req,
	input wire logic		front_rd_event,
	input wire logic		front_rd_busy,
	input wire logic		front_rd_valid,
	input wire logic		rear_rd_req,
	input wire logic		rear_rd_event,
	input wire logic		rear_rd_busy,
	input wire logic		rear_rd_valid,
	input wire logic		backlight_on,
	input wire logic		settings_mode,
	input wire logic		trip_cmd
);
	logic [31:0]	bl_q;
	logic [31:0]	hold_q;
	wire [3:0]	kv = {menu_key, inc_key, dec_key, records_key};
	wire [16:0]	mag = smp_data[15] ? 17'h1_0000 - {1'b0, smp_data} : {1'b0, smp_data};
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// Cycles since the last cause that lights the backlight
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			bl_q <= 32'hffff_ffff;
		else if (|(kv & ~$past(kv)) || $rose(trip_cmd))
			bl_q <= '0;
		else if (bl_q != 32'hffff_ffff)
			bl_q <= bl_q + 1;
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n || !menu_key)
			hold_q <= '0;
		else
			hold_q <= hold_q + 1;
	end
	hand_dark_a: assert property ($rose(hand_reset_key) && !backlight_on
		&& !trip_cmd && !smp_valid && kv == 4'h0 |=> !backlight_on)
		else $error("hand key lit backlight");
	key_light_a: assert property (|(kv & ~$past(kv)) |-> ##[1:3] backlight_on)
		else $error("key left backlight dark");
	bl_hold_a: assert property (bl_q > 3 && bl_q < BL_CYCLES - 3 |-> backlight_on)
		else $error("backlight dropped early");
	bl_off_a: assert property (bl_q > BL_CYCLES + 3 |-> !backlight_on)
		else $error("backlight stayed lit");
	trip_light_a: assert property ($rose(trip_cmd) |-> ##[0:2] backlight_on)
		else $error("trip left backlight dark");
	trip_set_a: assert property (smp_valid && mag > {1'b0, trip_level} |=> trip_cmd)
		else $error("large sample did not trip");
	trip_clr_a: assert property ($rose(menu_key) && trip_cmd && !settings_mode
		|-> ##[1:3] !trip_cmd) else $error("menu key kept trip");
	hold_need_a: assert property ($rose(settings_mode) |-> hold_q >= HOLD_CYCLES - 2)
		else $error("settings without hold");
	ev_read_a: assert property (front_rd_req && !front_rd_busy && front_rd_event
		|=> front_rd_busy [*2] ##1 front_rd_valid) else $error("event read latency");
	wave_read_a: assert property (rear_rd_req && !rear_rd_busy && !rear_rd_event
		|-> ##4 rear_rd_valid) else $error("wave read latency");
	cover property ($rose(settings_mode));
	cover property ($rose(trip_cmd));
	cover property (rear_rd_valid);
endmodule : recorder_sva
bind fault_event_disturbance_recorder recorder_sva #(.BL_CYCLES(BL_CYCLES),
	.HOLD_CYCLES(HOLD_CYCLES)) sva_i (.*);
`default_nettype wire

//--- tb/adc_source.sv
// Purpose: converter model pacing current samples
// Assumes: bench changes level between strobes
// Notes:   data line alternates between the sample and its inverse between strobes
`timescale 1ns/1ps
`default_nettype none
module adc_source
	import recorder_pkg::*;
#(
	parameter int GAP = 4
) (
	input wire logic		core_clk,
	input wire logic		rst_n,
	input wire logic		run,
	input wire logic [SMP_W-1:0]	level,
	output logic			smp_valid,
	output logic [SMP_W-1:0]	smp_data
);
	int gap_q;
	always_ff @(posedge core_clk) begin
		if (!rst_n || !run) begin
			gap_q <= 0;
			smp_valid <= 1'b0;
		end else begin
			gap_q <= (gap_q == GAP - 1) ? 0 : gap_q + 1;
			smp_valid <= gap_q == 0;
		end
	end
	// Inverted off strobe so a late capture shows as a mismatch
	always_ff @(posedge core_clk)
		smp_data <= (gap_q == 0) ? level : ~smp_data;
endmodule : adc_source
`default_nettype wire

//--- tb/fault_event_disturbance_recorder_test.sv
// Purpose: self-checking bench of the recorder
// Assumes: shortened counts, converter model paces samples
// Notes:   newest event sits in raw slot event_count - 1
`timescale 1ns/1ps
`default_nettype none
module fault_event_disturbance_recorder_test
	import recorder_pkg::*;
;
	localparam int MSC = 10;
	localparam int BL = 50;
	localparam int HLD = 20;
	localparam logic [15:0] TV [2] = '{16'h5000, 16'h9000};
	localparam logic [3:0] EVS [6] = '{EV_TCS, EV_CB_TRIP, EV_CB_CLOSE, EV_STATUS, EV_SET_GUI, EV_ERROR};
	logic		core_clk = 1'b0;
	logic		rst_n = 1'b0;
	logic [4:0]	keys = '0;
	wire		menu_key = keys[0], inc_key = keys[1], dec_key = keys[2];
	wire		records_key = keys[3], hand_reset_key = keys[4];
	logic		settings_done = 1'b0, gui_setting_changed = 1'b0, run = 1'b0;
	logic [SMP_W-1:0]	level = '0, pickup_level = 16'h1000;
	logic [SMP_W-1:0]	trip_level = 16'h4000, inst_level = 16'h6000;
	logic [STAT_W-1:0]	status_in = '0;
	logic		cb_open = 1'b0, cb_closed = 1'b1, tcs_fail = 1'b0, relay_error = 1'b0;
	logic [1:0]	rq = '0;
	logic		re = 1'b0;
	logic [REC_W-1:0]	rr = '0;
	logic [EVT_AW-1:0]	ri = '0, e0;
	wire		front_rd_req = rq[0], rear_rd_req = rq[1];
	wire		front_rd_event = re, rear_rd_event = re;
	wire [REC_W-1:0]	front_rd_rec = rr, rear_rd_rec = rr, wave_count, newest_rec;
	wire [EVT_AW-1:0]	front_rd_idx = ri, rear_rd_idx = ri, event_count;
	wire		smp_valid, front_rd_busy, rear_rd_busy, front_rd_valid, rear_rd_valid;
	wire		backlight_on, settings_mode, select_pulse, inc_pulse, dec_pulse;
	wire		records_view, trip_cmd, pickup;
	wire [SMP_W-1:0]	smp_data;
	wire [EVT_W-1:0]	rd_data;
	wire [1:0]	fault_type;
	wire [TS_W-1:0]	timestamp_ms;
	wire [1:0]	vv = {rear_rd_valid, front_rd_valid};
	int		errors = 0, cmp_count = 0;
	int		pc [3] = '{0, 0, 0};
	logic [31:0]	seed = 32'hc43b7a08, ts0;
	logic [SMP_W-1:0]	p, c;
	logic [REC_W-1:0]	w0;
	logic [EVT_W-1:0]	d;

	always #10 core_clk = ~core_clk;
	fault_event_disturbance_recorder #(.MS_CYCLES(MSC), .BL_CYCLES(BL), .HOLD_CYCLES(HLD)) DUT (.*);
	adc_source #(.GAP(4)) ADC (.*);
	always @(negedge core_clk) begin
		if (select_pulse === 1'b1) pc[0]++;
		if (inc_pulse === 1'b1) pc[1]++;
		if (dec_pulse === 1'b1) pc[2]++;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [1:0] ftype(input logic [15:0] v);
		logic [16:0] m;
		m = v[15] ? 17'h1_0000 - {1'b0, v} : {1'b0, v};
		if (m > {1'b0, inst_level}) return FT_INST;
		return (m > {1'b0, trip_level}) ? FT_OVER : FT_NONE;
	endfunction : ftype
	task automatic chk(input string n, input logic [67:0] s, input logic [67:0] x);
		cmp_count++;
		if (s !== x) begin
			errors++;
			$display("unexpected %s: expected %0h, seen %0h", n, x, s);
		end
	endtask : chk
	task automatic results();
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	task automatic wt(input int n);
		repeat (n) @(negedge core_clk);
	endtask : wt
	task automatic hold(input int i, input int n);
		keys[i] = 1'b1;
		wt(n);
		keys[i] = 1'b0;
		wt(4);
	endtask : hold
	task automatic send(input logic [15:0] v, input int n);
		level = v;
		repeat (n) begin
			wt(1);
			while (smp_valid !== 1'b1) wt(1);
		end
	endtask : send
	task automatic rd(input int pt, input logic e, input int r, input int i);
		int t;
		rq[pt] = 1'b1;
		re = e;
		rr = r[REC_W-1:0];
		ri = i[EVT_AW-1:0];
		wt(1);
		rq[pt] = 1'b0;
		for (t = 0; t < 9 && vv[pt] !== 1'b1; t++) wt(1);
		chk("read answer", vv[pt], 1'b1);
		d = rd_data;
	endtask : rd
	task automatic evc(input int pt, input logic [3:0] code);
		rd(pt, 1'b1, 0, int'(event_count) - 1);
		chk("event code", d[35:32], code);
	endtask : evc

	initial begin
		wt(3);
		rst_n = 1'b1;
		run = 1'b1;
		wt(BL + 9);
		hold(4, 3);
		chk("hand reset light", backlight_on, 1'b0);
		hold(3, 2);
		chk("records view", records_view, 1'b1);
		wt(BL - 15);
		chk("backlight held", backlight_on, 1'b1);
		wt(20);
		chk("backlight off", backlight_on, 1'b0);
		hold(1, 2);
		chk("inc in run mode", pc[1], 0);
		hold(0, HLD / 2);
		chk("short hold", settings_mode, 1'b0);
		hold(0, HLD + 4);
		chk("long hold", settings_mode, 1'b1);
		pc = '{0, 0, 0};
		hold(1, 2);
		hold(2, 2);
		hold(0, 2);
		for (int i = 0; i < 3; i++) chk("key pulse", pc[i], 1);
		settings_done = 1'b1;
		wt(1);
		settings_done = 1'b0;
		wt(5);
		chk("settings exit", settings_mode, 1'b0);
		evc(1, EV_SET_KEY);
		ts0 = timestamp_ms;
		wt(20 * MSC);
		chk("ms stamp", timestamp_ms - ts0, 20);
		$display("panel test finished");
		for (int k = 0; k < 2; k++) begin
			p = 16'(xs()) & 16'h0fff;
			c = 16'(xs()) & 16'h0fff;
			w0 = wave_count;
			send(p, 1500);
			send(TV[k], 1);
			wt(3);
			chk("trip", trip_cmd, 1'b1);
			chk("fault type", fault_type, ftype(TV[k]));
			chk("trip backlight", backlight_on, 1'b1);
			chk("pickup", pickup, 1'b1);
			send(c, 170);
			wt(8);
			chk("capture count", wave_count, w0 + 8'h01);
			chk("pickup drop", pickup, 1'b0);
			rd(0, 1'b0, int'(newest_rec), 100);
			chk("pre sample", d, p);
			rd(1, 1'b0, int'(newest_rec), REC_LEN - 1);
			chk("post sample", d, c);
			evc(k, EV_PROT_TRIP);
			if (k == 0) chk("trip current", d[31:16], TV[0]);
			hold(k * 4, 2);
			chk("trip reset", trip_cmd, 1'b0);
			evc(k, EV_RESET);
		end
		$display("capture test finished");
		for (int k = 0; k < 6; k++) begin
			e0 = event_count;
			case (k)
				0: tcs_fail = 1'b1;
				1: {cb_open, cb_closed} = 2'b10;
				2: {cb_open, cb_closed} = 2'b01;
				3: status_in = STAT_W'(xs()) | 13'h0001;
				4: gui_setting_changed = 1'b1;
				default: relay_error = 1'b1;
			endcase
			wt(1);
			gui_setting_changed = 1'b0;
			wt(6);
			chk("event count", event_count, e0 + 13'h0001);
			evc(k % 2, EVS[k]);
		end
		$display("event test finished");
		results();
	end
	initial begin
		wt(40000);
		errors++;
		results();
	end
endmodule : fault_event_disturbance_recorder_test
`default_nettype wire
